// ===== dpdc_codec.sv
// drive process data codec: decodes output words, builds input words
// assumes word strobe and data arrive from same-clock framing logic;
// switch and terminal inputs are asynchronous and synchronised here
`include "dpdc_defines.svh"
`timescale 1ns/1ps
module dpdc_codec
   import dpdc_pkg::*;
#(
   parameter int ADDR_W = 4
)(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // process output words from the master
   input  wire logic              po_valid,
   input  wire logic              po_three_words,
   input  wire logic [15:0]       control_out_word,
   input  wire logic [15:0]       speed_setpoint_word,
   input  wire logic [15:0]       ramp_time_word,
   // local configuration, asynchronous
   input  wire logic [ADDR_W-1:0] station_address,
   input  wire logic              brake_release_option_switch,
   input  wire logic              hoist_mode,
   input  wire logic [15:0]       ramp_selector_switch,
   input  wire logic              process_data_inhibit,
   // terminals and drive state, asynchronous
   input  wire logic              clockwise_input_flag,
   input  wire logic              counterclockwise_input_flag,
   input  wire logic              setpoint_changeover_input_flag,
   input  wire logic              aux_supply_only,
   input  wire logic              manual_mode,
   input  wire logic              inverter_ready,
   input  wire logic              fault_event,
   input  wire logic [7:0]        fault_number,
   // drive measurement, same clock, registered once
   input  wire logic [15:0]       output_current_word,
   // commands to the drive
   output logic                   output_stage_enable,
   output logic                   stop_on_ramp,
   output logic                   brake_output_flag,
   output logic                   ready_output_flag,
   output logic                   fault_present,
   output logic signed [15:0]     speed_command,
   output logic [15:0]            active_ramp_ms,
   // process input words, returned in this order
   output logic [15:0]            primary_status_word,
   output logic [15:0]            current_status_word,
   output logic [15:0]            secondary_status_word
);
   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // address, ten single flags, fault number and ten switch bits
   localparam int SN = ADDR_W + 28;
   logic [SN-1:0] sync1;
   logic [SN-1:0] sync2;
   wire  [SN-1:0] raw = {station_address,
                         brake_release_option_switch,
                         hoist_mode,
                         process_data_inhibit,
                         clockwise_input_flag,
                         counterclockwise_input_flag,
                         setpoint_changeover_input_flag,
                         aux_supply_only,
                         manual_mode,
                         inverter_ready,
                         fault_event,
                         fault_number,
                         ramp_selector_switch[9:0]};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end
   // switch code is static; only low ten bits carried, enough for 1023 ms
   wire [ADDR_W-1:0] s_addr   = sync2[SN-1 -: ADDR_W];
   wire              s_brkopt = sync2[27];
   wire              s_hoist  = sync2[26];
   wire              s_inhib  = sync2[25];
   wire              s_cw     = sync2[24];
   wire              s_ccw    = sync2[23];
   wire              s_chg    = sync2[22];
   wire              s_aux    = sync2[21];
   wire              s_manual = sync2[20];
   wire              s_ready  = sync2[19];
   wire              s_fevt   = sync2[18];
   wire [7:0]        s_fnum   = sync2[17:10];
   wire [15:0]       s_sw_ms  = {6'h00, sync2[9:0]};

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   wire pd_enabled  = !s_inhib && (s_addr != '0);
   wire take        = po_valid && pd_enabled;
   wire dir_ok      = s_cw || s_ccw;
   wire cmd_enable  = (control_out_word & `DPDC_CTL_CMD_MASK) == `DPDC_CTL_ENABLE;
   wire cmd_stop    = !control_out_word[`DPDC_CTL_STOP_BIT];
   wire cmd_reset   = control_out_word[`DPDC_CTL_RESET_BIT];
   wire cmd_brk_rel = control_out_word[`DPDC_CTL_BRK_REL_BIT];
   wire cmd_brk_app = control_out_word[`DPDC_CTL_BRK_APP_BIT];
   // unassigned bits are expected zero from the master and simply ignored

   logic [15:0]  ctl;
   logic         fault;
   logic [7:0]   fnum;
   dpdc_drive_e  state;
   dpdc_drive_e  next_state;
   logic         brake_applied;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl           <= 16'h0000;
         speed_command <= 16'sh0000;
      end else if (take) begin
         ctl           <= control_out_word;
         speed_command <= speed_setpoint_word;
      end
   end

   // fault: event set wins over acknowledge
   wire fault_ack = take && cmd_reset && fault;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault <= 1'b0;
         fnum  <= 8'h00;
      end else if (s_fevt) begin
         fault <= 1'b1;
         fnum  <= s_fnum;
      end else if (fault_ack) begin
         fault <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // drive state
   // ---------------------------------------------------------------
   wire c_enable = (ctl & `DPDC_CTL_CMD_MASK) == `DPDC_CTL_ENABLE;
   wire c_stop   = !ctl[`DPDC_CTL_STOP_BIT];
   wire c_app    = ctl[`DPDC_CTL_BRK_APP_BIT];
   wire c_rel    = ctl[`DPDC_CTL_BRK_REL_BIT];
   wire can_run  = c_enable && dir_ok && !fault;

   always_comb begin
      next_state = state;
      unique case (state)
         DPDC_INHIBIT: if (can_run) next_state = DPDC_RUN;
         DPDC_RUN:     if (c_stop || !dir_ok || fault) next_state = DPDC_STOP;
                       else if (!c_enable) next_state = DPDC_STOP;
         DPDC_STOP:    if (c_app || fault) next_state = DPDC_INHIBIT;
                       else if (can_run) next_state = DPDC_RUN;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) state <= DPDC_INHIBIT;
      else     state <= next_state;
   end

   wire rel_no_en = s_brkopt && !s_hoist && c_rel;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) brake_applied <= 1'b1;
      else     brake_applied <= !(next_state != DPDC_INHIBIT || rel_no_en);
   end

   assign output_stage_enable = state != DPDC_INHIBIT;
   assign stop_on_ramp        = state == DPDC_STOP;
   assign brake_output_flag   = brake_applied;
   assign fault_present       = fault;

   // ---------------------------------------------------------------
   // ramp selection
   // ---------------------------------------------------------------
   logic [15:0] ramp_word;
   logic        three_words;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ramp_word   <= `DPDC_RAMP_MAX_MS;
         three_words <= 1'b0;
      end else if (take) begin
         ramp_word   <= ramp_time_word;
         three_words <= po_three_words;
      end
   end

   dpdc_ramp_if rif ();
   assign rif.ramp_word   = ramp_word;
   assign rif.three_words = three_words;
   assign rif.switch_ms   = s_sw_ms;
   dpdc_ramp_sel u_ramp (.rif(rif));
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) active_ramp_ms <= `DPDC_RAMP_MAX_MS;
      else     active_ramp_ms <= rif.ramp_ms;
   end

   // ---------------------------------------------------------------
   // status words
   // ---------------------------------------------------------------
   wire [7:0] unit_code = s_manual ? `DPDC_UNIT_MANUAL :
                          s_aux    ? `DPDC_UNIT_AUX_ONLY :
                          output_stage_enable ? `DPDC_UNIT_ENABLED : `DPDC_UNIT_NO_ENABLE;
   wire [7:0] hi_byte   = fault ? fnum : unit_code;
   wire [7:0] lo_flags  = {2'b00, fault, 2'b00, pd_enabled, s_ready, output_stage_enable};
   wire rdy_out         = s_ready && !fault;
   wire [15:0] st2      = {3'b000, s_chg, s_ccw, s_cw, rdy_out, brake_applied, lo_flags};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         primary_status_word   <= 16'h0000;
         current_status_word   <= 16'h0000;
         secondary_status_word <= 16'h0000;
         ready_output_flag     <= 1'b0;
      end else begin
         primary_status_word   <= {hi_byte, lo_flags};
         current_status_word   <= output_current_word;
         secondary_status_word <= st2;
         ready_output_flag     <= rdy_out;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_enable_needs_dir: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(output_stage_enable) |-> $past(dir_ok)) else $error("enabled without direction");
   a_stop_leaves_run: assert property (@(posedge ref_clk) disable iff (rst)
      (state == DPDC_RUN && c_stop) |=> state == DPDC_STOP) else $error("stop not taken");
   a_fault_ack_clears: assert property (@(posedge ref_clk) disable iff (rst)
      (fault_ack && !s_fevt) |=> !fault) else $error("fault not cleared");
   a_brake_apply_inh: assert property (@(posedge ref_clk) disable iff (rst)
      (state == DPDC_STOP && c_app) |=> state == DPDC_INHIBIT ##1 brake_applied) else $error("brake apply");
   a_brake_rel_opt: assert property (@(posedge ref_clk) disable iff (rst)
      rel_no_en |=> !brake_applied) else $error("brake not released");
   a_ramp_in_range: assert property (@(posedge ref_clk) disable iff (rst)
      three_words |=> (active_ramp_ms >= `DPDC_RAMP_MIN_MS && active_ramp_ms <= `DPDC_RAMP_MAX_MS))
      else $error("ramp out of range");
   a_inhibit_ignores: assert property (@(posedge ref_clk) disable iff (rst)
      !pd_enabled |=> $stable(ctl) && $stable(speed_command)) else $error("command taken while inhibited");
   a_status_fault_byte: assert property (@(posedge ref_clk) disable iff (rst)
      fault |=> primary_status_word[`DPDC_ST_FAULT_BIT] && primary_status_word[15:8] == $past(fnum))
      else $error("fault byte wrong");
   a_status_pd_bit: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> primary_status_word[`DPDC_ST_PD_EN_BIT] == $past(pd_enabled)) else $error("pd bit wrong");
   a_status2_mirror: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> secondary_status_word[7:0] == primary_status_word[7:0] && secondary_status_word[15:13] == 3'b000)
      else $error("status 2 mirror");
   a_status1_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> primary_status_word[7:6] == 2'b00 && primary_status_word[4:3] == 2'b00)
      else $error("status 1 reserved bits set");
   a_unit_code_en: assert property (@(posedge ref_clk) disable iff (rst)
      (!fault && !s_manual && !s_aux) |=> primary_status_word[15:8] ==
      ($past(output_stage_enable) ? `DPDC_UNIT_ENABLED : `DPDC_UNIT_NO_ENABLE))
      else $error("unit code wrong");
   a_status2_inputs: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> secondary_status_word[12:10] == $past({s_chg, s_ccw, s_cw}))
      else $error("status 2 inputs wrong");
   a_current_pass: assert property (@(posedge ref_clk) disable iff (rst)
      1'b1 |=> current_status_word == $past(output_current_word))
      else $error("current word wrong");
   a_speed_take: assert property (@(posedge ref_clk) disable iff (rst)
      take |=> speed_command == $past(speed_setpoint_word))
      else $error("speed not taken");
   a_switch_ramp: assert property (@(posedge ref_clk) disable iff (rst)
      !three_words |=> active_ramp_ms == $past(s_sw_ms))
      else $error("switch ramp not used");

   c_run_seen:   cover property (@(posedge ref_clk) disable iff (rst) state == DPDC_RUN);
   c_stop_brake: cover property (@(posedge ref_clk) disable iff (rst) state == DPDC_STOP ##1 state == DPDC_INHIBIT);
   c_fault_ack:  cover property (@(posedge ref_clk) disable iff (rst) fault ##1 !fault);
   c_rel_no_en:  cover property (@(posedge ref_clk) disable iff (rst) rel_no_en && state == DPDC_INHIBIT);
   c_three_take: cover property (@(posedge ref_clk) disable iff (rst) take && po_three_words);
endmodule

// ===== dpdc_defines.svh
// constants for the drive process data codec: field positions, codes, limits
// assumes inclusion by the codec and ramp selector modules by bare name
//
// Function
// - control word low three bits equal to 6 request drive enable
// - enable granted only while clockwise or counterclockwise input is active
// - control bit 2 low always stops along the active ramp
// - control bit 6 set during a fault acknowledges and clears it
// - bit 8 releases brake without enable if option switch on, not hoist
// - bit 9 after a stop applies brake and inhibits the output stage
// - speed word is signed fraction, C000 minus full, 4000 plus full
// - three words take ramp from third word, two words use selector switch
// - ramp word is unsigned milliseconds, valid range 100 to 10000
// - ramp time scales a setpoint change of 1500 rpm, 50 Hz
// - input words returned in order status 1, current, status 2
// - output current is signed 16 bit in 0.1 percent of nominal
// - status 1 bits 0,1,2,5 are enabled, ready, accepted, fault; rest of low byte zero
// - with fault set, upper byte of status 1 holds fault number
// - without fault, upper byte holds unit status 0, 2, 4 or 18
// - process data inhibited clears bit 2 and ignores master commands
// - status 2 repeats low flags, bit 8 brake applied, bit 9 ready output
// - status 2 bits 10..12 mirror direction and changeover inputs, 13..15 zero
// - output data applied only when station address is nonzero
`ifndef DPDC_DEFINES_SVH
`define DPDC_DEFINES_SVH

`define DPDC_CTL_CMD_MASK    16'h0007
`define DPDC_CTL_ENABLE      16'h0006
`define DPDC_CTL_STOP_BIT    2
`define DPDC_CTL_RESET_BIT   6
`define DPDC_CTL_BRK_REL_BIT 8
`define DPDC_CTL_BRK_APP_BIT 9

`define DPDC_SPEED_NEG_FULL  16'hC000
`define DPDC_SPEED_POS_FULL  16'h4000

`define DPDC_RAMP_MIN_MS     16'h0064
`define DPDC_RAMP_MAX_MS     16'h2710
`define DPDC_RAMP_REF_RPM    1500

`define DPDC_ST_OUT_EN_BIT   0
`define DPDC_ST_READY_BIT    1
`define DPDC_ST_PD_EN_BIT    2
`define DPDC_ST_FAULT_BIT    5
`define DPDC_ST2_BRAKE_BIT   8
`define DPDC_ST2_RDYOUT_BIT  9
`define DPDC_ST2_CW_BIT      10
`define DPDC_ST2_CCW_BIT     11
`define DPDC_ST2_CHG_BIT     12

`define DPDC_UNIT_AUX_ONLY   8'h00
`define DPDC_UNIT_NO_ENABLE  8'h02
`define DPDC_UNIT_ENABLED    8'h04
`define DPDC_UNIT_MANUAL     8'h12

`endif

// ===== dpdc_pkg.sv
// types for the drive process data codec
// assumes the defines header is compiled alongside
package dpdc_pkg;
   typedef logic [15:0] dpdc_word_t;

   typedef enum logic [2:0] {
      DPDC_INHIBIT = 3'b001,
      DPDC_RUN     = 3'b010,
      DPDC_STOP    = 3'b100
   } dpdc_drive_e;
endpackage

// ===== dpdc_ramp_if.sv
// carries the ramp word from the codec to the ramp selector
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
interface dpdc_ramp_if;
   logic [15:0] ramp_word;
   logic        three_words;
   logic [15:0] switch_ms;
   logic [15:0] ramp_ms;
   modport codec (output ramp_word, output three_words, output switch_ms, input ramp_ms);
   modport sel   (input ramp_word, input three_words, input switch_ms, output ramp_ms);
endinterface

// ===== dpdc_ramp_sel.sv
// chooses the active ramp time in milliseconds; clamps only the third-word ramp
// assumes a synchronous caller on ref_clk; purely combinational
`include "dpdc_defines.svh"
`timescale 1ns/1ps
module dpdc_ramp_sel
   import dpdc_pkg::*;
(
   dpdc_ramp_if.sel rif
);
   wire        too_low  = rif.ramp_word < `DPDC_RAMP_MIN_MS;
   wire        too_high = rif.ramp_word > `DPDC_RAMP_MAX_MS;
   wire [15:0] clamped  = too_low  ? `DPDC_RAMP_MIN_MS :
                          too_high ? `DPDC_RAMP_MAX_MS : rif.ramp_word;
   // times count a 1500 rpm step in both paths, so no rescale here
   assign rif.ramp_ms = rif.three_words ? clamped : rif.switch_ms;
endmodule

// ===== dpdc_master_model.sv
// far-side master model: hands process output words to the codec
// assumes the bench clock; words change only at the falling edge
`timescale 1ns/1ps
module dpdc_master_model (
   // clock
   input  wire logic        ref_clk,
   // process output words
   output logic             po_valid,
   output logic             po_three_words,
   output logic [15:0]      control_out_word,
   output logic [15:0]      speed_setpoint_word,
   output logic [15:0]      ramp_time_word
);
   // ----------------------------------------
   // one transfer per call
   // ----------------------------------------
   initial begin
      po_valid            = 1'b0;
      po_three_words      = 1'b0;
      control_out_word    = 16'h0000;
      speed_setpoint_word = 16'h0000;
      ramp_time_word      = 16'h0000;
   end
   // words are valid only in the strobe cycle; afterwards they show the inverse,
   // so a design that samples late cannot pass by luck
   task automatic send(input logic [15:0] ctl, input logic [15:0] spd, input logic [15:0] rmp, input logic three);
      @(negedge ref_clk);
      po_valid            <= 1'b1;
      po_three_words      <= three;
      control_out_word    <= ctl & 16'h0347;
      speed_setpoint_word <= spd;
      ramp_time_word      <= rmp;
      @(negedge ref_clk);
      po_valid            <= 1'b0;
      po_three_words      <= ~three;
      control_out_word    <= ~control_out_word;
      speed_setpoint_word <= ~spd;
      ramp_time_word      <= ~rmp;
   endtask
endmodule

// ===== dpdc_codec_tb_top.sv
// self-checking bench for the process data codec
// assumes the master model drives the output words; all waits are fixed counts
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module dpdc_codec_tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic               ref_clk, rst, po_valid, po_three_words, fault_event;
   logic        [15:0] control_out_word, speed_setpoint_word, ramp_time_word, ramp_selector_switch;
   logic        [15:0] output_current_word, active_ramp_ms;
   logic        [15:0] primary_status_word, current_status_word, secondary_status_word;
   logic        [3:0]  station_address;
   logic        [7:0]  fault_number;
   logic               brake_release_option_switch, hoist_mode, process_data_inhibit, inverter_ready;
   logic               clockwise_input_flag, counterclockwise_input_flag, setpoint_changeover_input_flag;
   logic               aux_supply_only, manual_mode, output_stage_enable, stop_on_ramp;
   logic               brake_output_flag, ready_output_flag, fault_present;
   logic signed [15:0] speed_command;
   int                 n_mismatch, check_count;
   logic        [15:0] spd_tab [4] = '{16'hC000, 16'h4000, 16'hCCC5, 16'h0000};
   logic        [15:0] rmp_in  [4] = '{16'h0010, 16'h0064, 16'h2710, 16'hFFFF};
   logic        [15:0] rmp_exp [4] = '{16'h0064, 16'h0064, 16'h2710, 16'h2710};
   logic        [15:0] stop_tab [4] = '{16'h0002, 16'h0003, 16'h0001, 16'h0000};

   dpdc_codec dut_u (
      .ref_clk, .rst, .po_valid, .po_three_words, .control_out_word, .speed_setpoint_word, .ramp_time_word,
      .station_address, .brake_release_option_switch, .hoist_mode, .ramp_selector_switch,
      .process_data_inhibit, .clockwise_input_flag, .counterclockwise_input_flag,
      .setpoint_changeover_input_flag, .aux_supply_only, .manual_mode, .inverter_ready, .fault_event,
      .fault_number, .output_current_word, .output_stage_enable, .stop_on_ramp, .brake_output_flag,
      .ready_output_flag, .fault_present, .speed_command, .active_ramp_ms, .primary_status_word,
      .current_status_word, .secondary_status_word
   );
   dpdc_master_model master_u (
      .ref_clk, .po_valid, .po_three_words, .control_out_word, .speed_setpoint_word, .ramp_time_word
   );

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // status words settle three edges after the strobe
   task automatic put(input logic [15:0] c, input logic [15:0] s = 16'h2000, input logic [15:0] r = 16'h0BB8,
                      input logic t = 1'b1);
      master_u.send(c, s, r, t);
      step(3);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      rst = 1'b1; station_address = 4'h1; brake_release_option_switch = 1'b0; hoist_mode = 1'b0;
      ramp_selector_switch = 16'h01F4; process_data_inhibit = 1'b0; clockwise_input_flag = 1'b1;
      counterclockwise_input_flag = 1'b0; setpoint_changeover_input_flag = 1'b0; aux_supply_only = 1'b0;
      manual_mode = 1'b0; inverter_ready = 1'b1; fault_event = 1'b0; fault_number = 8'h00;
      output_current_word = 16'h0320;
      step(10);
      `CHK("brake", 1'b1, brake_output_flag)
      `CHK("ramp", 16'h2710, active_ramp_ms)
      rst = 1'b0;
      step(3);
      put(16'h0006);
      `CHK("enable", 1'b1, output_stage_enable)
      `CHK("status1", 16'h0407, primary_status_word)
      `CHK("current", 16'h0320, current_status_word)
      `CHK("status2", 16'h0607, secondary_status_word)
      for (int i = 0; i < 4; i++) begin
         put(16'h0006, spd_tab[i], rmp_in[i]);
         `CHK("speed", spd_tab[i], speed_command)
         `CHK("ramp", rmp_exp[i], active_ramp_ms)
      end
      put(16'h0006, 16'h2000, 16'h0BB8, 1'b0);
      `CHK("switch ramp", 16'h01F4, active_ramp_ms)
      for (int i = 0; i < 4; i++) begin
         put(16'h0006);
         `CHK("run", 1'b0, stop_on_ramp)
         put(stop_tab[i]);
         `CHK("stop", 1'b1, stop_on_ramp)
      end
      put(16'h0202);
      `CHK("inhibit", 1'b0, output_stage_enable)
      `CHK("brake", 1'b1, brake_output_flag)
      `CHK("status1", 16'h0206, primary_status_word)
      `CHK("status2", 16'h0706, secondary_status_word)
      clockwise_input_flag = 1'b0;
      step(5);
      put(16'h0006);
      `CHK("no direction", 1'b0, output_stage_enable)
      counterclockwise_input_flag = 1'b1; setpoint_changeover_input_flag = 1'b1;
      step(5);
      put(16'h0006);
      `CHK("ccw enable", 1'b1, output_stage_enable)
      `CHK("status2", 16'h1A07, secondary_status_word)
      put(16'h0002);
      put(16'h0202);
      brake_release_option_switch = 1'b1; hoist_mode = 1'b1;
      step(5);
      put(16'h0100);
      `CHK("hoist brake", 1'b1, brake_output_flag)
      hoist_mode = 1'b0;
      step(5);
      put(16'h0100);
      `CHK("brake release", 1'b0, brake_output_flag)
      fault_number = 8'h2A; fault_event = 1'b1;
      step(1);
      fault_event = 1'b0;
      step(5);
      `CHK("fault", 1'b1, fault_present)
      `CHK("ready out", 1'b0, ready_output_flag)
      `CHK("status1", 16'h2A26, primary_status_word)
      put(16'h0040);
      `CHK("fault ack", 1'b0, fault_present)
      `CHK("status1", 16'h0206, primary_status_word)
      manual_mode = 1'b1;
      step(5);
      `CHK("manual", 8'h12, primary_status_word[15:8])
      manual_mode = 1'b0; aux_supply_only = 1'b1;
      step(5);
      `CHK("aux", 8'h00, primary_status_word[15:8])
      aux_supply_only = 1'b0; station_address = 4'h0; output_current_word = 16'hFCE0;
      step(5);
      put(16'h0006);
      `CHK("addr0", 1'b0, output_stage_enable)
      `CHK("addr0 pd", 1'b0, primary_status_word[2])
      `CHK("current", 16'hFCE0, current_status_word)
      station_address = 4'h1; process_data_inhibit = 1'b1;
      step(5);
      put(16'h0006);
      `CHK("inhibited", 1'b0, output_stage_enable)
      `CHK("inhibited pd", 1'b0, primary_status_word[2])
      process_data_inhibit = 1'b0;
      step(5);
      put(16'h0006);
      `CHK("resumed", 1'b1, output_stage_enable)
      final_report();
   end
endmodule
